// [design/ahpd_cfg.svh]
`ifndef AHPD_CFG_SVH
`define AHPD_CFG_SVH
`define AHPD_A_DATA 3'h0
`define AHPD_A_ERRFEAT 3'h1
`define AHPD_A_SECCNT 3'h2
`define AHPD_A_SECNUM 3'h3
`define AHPD_A_CYLLO 3'h4
`define AHPD_A_CYLHI 3'h5
`define AHPD_A_DRVHD 3'h6
`define AHPD_A_STATCMD 3'h7
`define AHPD_A_ALTCTL 3'h6
`define AHPD_A_DRVADR 3'h7
`define AHPD_RST_FEAT 8'h00
`define AHPD_RST_SECCNT 8'h01
`define AHPD_RST_SECNUM 8'h01
`define AHPD_RST_CYL 8'h00
`define AHPD_RST_DRVHD 8'h00
`define AHPD_RST_DEVCTL 8'h08
`define AHPD_DC_SRST 2
`define AHPD_DC_INT_OFF 1
`define AHPD_DH_DRIVE 4
`define AHPD_SYS_NS 8
`define AHPD_TRP0_NS 160
`define AHPD_TRP1_NS 125
`define AHPD_TRP2_NS 100
`define AHPD_TSS_NS 50
`define AHPD_TSR0_NS 50
`define AHPD_CEIL(t) (((t) + `AHPD_SYS_NS - 1) / `AHPD_SYS_NS)
`define AHPD_FLOOR(t) ((t) / `AHPD_SYS_NS)
`define AHPD_TRP0_CYC `AHPD_CEIL(`AHPD_TRP0_NS)
`define AHPD_TRP1_CYC `AHPD_CEIL(`AHPD_TRP1_NS)
`define AHPD_TRP2_CYC `AHPD_CEIL(`AHPD_TRP2_NS)
`define AHPD_TSS_CYC `AHPD_CEIL(`AHPD_TSS_NS)
`define AHPD_TSR0_CYC `AHPD_FLOOR(`AHPD_TSR0_NS)
`define AHPD_FIFO_WIDTH 16
`define AHPD_FIFO_DEPTH 8
`define AHPD_FIFO_SLACK 3
`endif

// [design/ahpd_pkg.sv]
package ahpd_pkg;
    typedef enum logic [1:0] {
        AHPD_IDLE  = 2'b00,
        AHPD_BURST = 2'b01,
        AHPD_STOP  = 2'b10,
        AHPD_DONE  = 2'b11
    } ahpd_burst_t;

    typedef struct packed {
        logic        cmd_sel_n;
        logic        ctl_sel_n;
        logic        rd_n;
        logic        wr_n;
        logic [2:0]  da;
        logic [15:0] dd;
    } ahpd_host_t;

    typedef struct packed {
        logic [7:0] features;
        logic [7:0] sec_cnt;
        logic [7:0] sec_num;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] drv_hd;
        logic [7:0] dev_ctl;
    } ahpd_regs_t;

    typedef struct packed {
        logic [15:0] data;
        logic [1:0]  oe;
    } ahpd_bus_t;

    typedef struct packed {
        ahpd_host_t  h1;
        ahpd_host_t  h2;
        ahpd_host_t  hl;
        logic        dk1;
        logic        dk2;
        logic        ov1;
        logic        ov2;
        ahpd_regs_t  regs;
        ahpd_bus_t   bus;
        logic        io16_n;
        logic [7:0]  cmd_code;
        logic        cmd_strobe;
        logic [15:0] pio_wdata;
        logic        pio_wstrobe;
        logic        pio_rstrobe;
        ahpd_burst_t burst;
        logic        dmarq;
        logic        rdy_n;
        logic [7:0]  trp;
        logic [7:0]  tss;
    } ahpd_sys_t;

    typedef struct packed {
        logic rs1;
        logic rs2;
        logic ovr;
    } ahpd_link_t;
endpackage

// [design/ahpd_port.sv]
`timescale 1ns/100ps
`include "ahpd_cfg.svh"

module ahpd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             wr_clk,
    input  wire logic             wr_rst_b,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_clk,
    input  wire logic             rd_rst_b,
    input  wire logic             rd_ce,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic [WIDTH-1:0]      rd_data,
    output logic [AW:0]           rd_level,
    output logic                  wr_moved
);
    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic [AW:0] sg1;
        logic [AW:0] sg2;
    } ahpd_wside_t;

    typedef struct packed {
        logic [AW:0]      bin;
        logic [AW:0]      gray;
        logic [AW:0]      sg1;
        logic [AW:0]      sg2;
        logic [AW:0]      sg3;
        logic             vld;
        logic [WIDTH-1:0] data;
    } ahpd_rside_t;

    logic [WIDTH-1:0] mem [DEPTH];
    ahpd_wside_t      w;
    ahpd_wside_t      next_w;
    ahpd_rside_t      r;
    ahpd_rside_t      next_r;
    logic             push;
    logic             empty;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [AW:0] to_bin(input logic [AW:0] g);
        logic [AW:0] b;
        b = g;
        for (int i = AW - 1; i >= 0; i--)
            b[i] = g[i] ^ b[i+1];
        return b;
    endfunction

    // full when write pointer is one lap ahead of synced read pointer
    assign wr_ready = (w.gray != {~w.sg2[AW:AW-1], w.sg2[AW-2:0]});
    assign push     = wr_valid && wr_ready;

    always_comb
    begin
        next_w     = w;
        next_w.sg1 = r.gray;
        next_w.sg2 = w.sg1;
        if (push)
        begin
            next_w.bin  = w.bin + 1'b1;
            next_w.gray = to_gray(next_w.bin);
        end
    end

    always_ff @(posedge wr_clk)
    begin
        if (!wr_rst_b)
            w <= '0;
        else
            w <= next_w;
        if (push)
            mem[w.bin[AW-1:0]] <= wr_data;
    end

    assign empty = (r.gray == r.sg2);

    always_comb
    begin
        next_r     = r;
        next_r.sg1 = w.gray;
        next_r.sg2 = r.sg1;
        next_r.sg3 = r.sg2;
        if (r.vld && rd_ready)
            next_r.vld = 1'b0;
        if (!empty && (!r.vld || rd_ready))
        begin
            next_r.data = mem[r.bin[AW-1:0]];
            next_r.vld  = 1'b1;
            next_r.bin  = r.bin + 1'b1;
            next_r.gray = to_gray(next_r.bin);
        end
    end

    always_ff @(posedge rd_clk)
    begin
        if (!rd_rst_b)
            r <= '0;
        else if (rd_ce)
            r <= next_r;
    end

    assign rd_valid = r.vld;
    assign rd_data  = r.data;
    assign rd_level = (to_bin(r.sg2) - r.bin) + {{AW{1'b0}}, r.vld};
    assign wr_moved = (r.sg2 != r.sg3);
endmodule

module ahpd_port
    import ahpd_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic        link_clk,
    input  wire logic        command_block_select_n,
    input  wire logic        control_block_select_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [2:0]  da,
    input  wire logic [15:0] dd_in,
    output logic [15:0]      dd_out,
    output logic [1:0]       dd_oe,
    output logic             io16_n,
    input  wire logic        dmack_n,
    output logic             dmarq,
    output logic             device_burst_ready_n,
    input  wire logic [7:0]  core_status,
    input  wire logic [7:0]  core_error,
    input  wire logic [15:0] core_rdata,
    input  wire logic        ecc_xfer,
    input  wire logic        write_gate,
    input  wire logic [2:0]  udma_mode,
    input  wire logic        burst_start,
    input  wire logic        burst_stop,
    output ahpd_regs_t       task_regs,
    output logic [7:0]       cmd_code,
    output logic             cmd_strobe,
    output logic [15:0]      pio_wdata,
    output logic             pio_wstrobe,
    output logic             pio_rstrobe,
    output logic             soft_reset,
    output logic             intr_off,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    output logic [15:0]      rx_data,
    output logic             rx_overrun
);
    localparam logic [3:0] PAUSE_LVL = 4'(`AHPD_FIFO_DEPTH - `AHPD_FIFO_SLACK);

    ahpd_sys_t  s;
    ahpd_sys_t  n;
    ahpd_link_t lk;
    ahpd_link_t next_lk;
    ahpd_host_t pins;
    logic       lx_ready;
    logic [3:0] rx_level;
    logic       rx_moved;

    // the selects already carry the host's primary/secondary choice
    function automatic logic cmd_blk(input ahpd_host_t h);
        return !h.cmd_sel_n && h.ctl_sel_n;
    endfunction

    function automatic logic ctl_blk(input ahpd_host_t h);
        return h.cmd_sel_n && !h.ctl_sel_n;
    endfunction

    function automatic logic [7:0] trp_cyc(input logic [2:0] m);
        unique case (m)
            3'h0: return 8'(`AHPD_TRP0_CYC);
            3'h1: return 8'(`AHPD_TRP1_CYC);
            3'h2, 3'h3, 3'h4: return 8'(`AHPD_TRP2_CYC);
            default: return 8'(`AHPD_TRP0_CYC);
        endcase
    endfunction

    assign pins = '{cmd_sel_n: command_block_select_n, ctl_sel_n: control_block_select_n,
                    rd_n: rd_n, wr_n: wr_n, da: da, dd: dd_in};

    // host strobe is the link clock; one word per rising edge
    ahpd_fifo #(
        .WIDTH (`AHPD_FIFO_WIDTH),
        .DEPTH (`AHPD_FIFO_DEPTH)
    ) u_fifo (
        .wr_clk   (link_clk),
        .wr_rst_b (lk.rs2),
        .wr_valid (lk.rs2),
        .wr_ready (lx_ready),
        .wr_data  (dd_in),
        .rd_clk   (sys_clk),
        .rd_rst_b (rst_b),
        .rd_ce    (clk_en),
        .rd_valid (rx_valid),
        .rd_ready (rx_ready),
        .rd_data  (rx_data),
        .rd_level (rx_level),
        .wr_moved (rx_moved)
    );

    always_comb
    begin
        next_lk     = lk;
        next_lk.rs1 = rst_b;
        next_lk.rs2 = lk.rs1;
        if (!lk.rs2)
            next_lk.ovr = 1'b0;
        else if (!lx_ready)
            next_lk.ovr = 1'b1;
    end

    always_ff @(posedge link_clk)
        lk <= next_lk;

    always_comb
    begin
        n             = s;
        n.h1          = pins;
        n.h2          = s.h1;
        n.dk1         = dmack_n;
        n.dk2         = s.dk1;
        n.ov1         = lk.ovr;
        n.ov2         = s.ov1;
        n.cmd_strobe  = 1'b0;
        n.pio_wstrobe = 1'b0;
        n.pio_rstrobe = 1'b0;
        if (!s.h2.wr_n || !s.h2.rd_n)
            n.hl = s.h2;
        // write effects on trailing edge of the synced strobe
        if (s.h2.wr_n && !s.hl.wr_n)
        begin
            n.hl.wr_n = 1'b1;
            if (cmd_blk(s.hl))
            begin
                unique case (s.hl.da)
                    `AHPD_A_DATA:
                    begin
                        n.pio_wdata   = s.hl.dd;
                        n.pio_wstrobe = 1'b1;
                    end
                    `AHPD_A_ERRFEAT: n.regs.features = s.hl.dd[7:0];
                    `AHPD_A_SECCNT: n.regs.sec_cnt = s.hl.dd[7:0];
                    `AHPD_A_SECNUM: n.regs.sec_num = s.hl.dd[7:0];
                    `AHPD_A_CYLLO: n.regs.cyl_lo = s.hl.dd[7:0];
                    `AHPD_A_CYLHI: n.regs.cyl_hi = s.hl.dd[7:0];
                    `AHPD_A_DRVHD: n.regs.drv_hd = s.hl.dd[7:0];
                    `AHPD_A_STATCMD:
                    begin
                        n.cmd_code   = s.hl.dd[7:0];
                        n.cmd_strobe = 1'b1;
                    end
                endcase
            end
            else if (ctl_blk(s.hl) && s.hl.da == `AHPD_A_ALTCTL)
                n.regs.dev_ctl = s.hl.dd[7:0];
        end
        if (s.h2.rd_n && !s.hl.rd_n)
        begin
            n.hl.rd_n = 1'b1;
            if (cmd_blk(s.hl) && s.hl.da == `AHPD_A_DATA)
                n.pio_rstrobe = 1'b1;
        end
        // read drive; released whenever the strobe is high
        n.bus    = '0;
        n.io16_n = !(cmd_blk(s.h2) && s.h2.da == `AHPD_A_DATA);
        if (!s.h2.rd_n && cmd_blk(s.h2))
        begin
            n.bus.oe = 2'b01;
            unique case (s.h2.da)
                `AHPD_A_DATA:
                begin
                    n.bus.data = core_rdata;
                    if (!ecc_xfer)
                        n.bus.oe = 2'b11;
                    else
                        n.bus.data[15:8] = 8'h00;
                end
                `AHPD_A_ERRFEAT: n.bus.data = {8'h00, core_error};
                `AHPD_A_SECCNT: n.bus.data = {8'h00, s.regs.sec_cnt};
                `AHPD_A_SECNUM: n.bus.data = {8'h00, s.regs.sec_num};
                `AHPD_A_CYLLO: n.bus.data = {8'h00, s.regs.cyl_lo};
                `AHPD_A_CYLHI: n.bus.data = {8'h00, s.regs.cyl_hi};
                `AHPD_A_DRVHD: n.bus.data = {8'h00, s.regs.drv_hd};
                `AHPD_A_STATCMD: n.bus.data = {8'h00, core_status};
            endcase
        end
        else if (!s.h2.rd_n && ctl_blk(s.h2) && s.h2.da[2:1] == 2'b11)
        begin
            n.bus.oe = 2'b01;
            if (s.h2.da == `AHPD_A_DRVADR)
                n.bus.data = {8'h00, 1'b0, !write_gate, ~s.regs.drv_hd[3:0],
                              !s.regs.drv_hd[`AHPD_DH_DRIVE], s.regs.drv_hd[`AHPD_DH_DRIVE]};
            else
                n.bus.data = {8'h00, core_status};
        end
        // countdown of tSS cycles from the last host strobe word
        if (rx_moved)
            n.tss = 8'(`AHPD_TSS_CYC);
        else if (s.tss != 8'h00)
            n.tss = s.tss - 8'h01;
        unique case (s.burst)
            AHPD_IDLE:
            begin
                n.rdy_n = 1'b1;
                if (burst_start)
                begin
                    n.dmarq = 1'b1;
                    n.burst = AHPD_BURST;
                end
            end
            AHPD_BURST:
            begin
                // no bound on waiting for the acknowledge
                n.rdy_n = s.dk2 || (rx_level >= PAUSE_LVL);
                if (burst_stop)
                begin
                    n.rdy_n = 1'b1;
                    n.trp   = trp_cyc(udma_mode);
                    n.burst = AHPD_STOP;
                end
            end
            AHPD_STOP:
            begin
                if (s.trp != 8'h00)
                    n.trp = s.trp - 8'h01;
                else if (s.tss == 8'h00 && !rx_moved)
                begin
                    n.dmarq = 1'b0;
                    n.burst = AHPD_DONE;
                end
            end
            AHPD_DONE:
                if (s.dk2)
                    n.burst = AHPD_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            s              <= '0;
            s.h1           <= '1;
            s.h2           <= '1;
            s.hl           <= '1;
            s.dk1          <= 1'b1;
            s.dk2          <= 1'b1;
            s.io16_n       <= 1'b1;
            s.rdy_n        <= 1'b1;
            s.burst        <= AHPD_IDLE;
            s.regs.features <= `AHPD_RST_FEAT;
            s.regs.sec_cnt <= `AHPD_RST_SECCNT;
            s.regs.sec_num <= `AHPD_RST_SECNUM;
            s.regs.cyl_lo  <= `AHPD_RST_CYL;
            s.regs.cyl_hi  <= `AHPD_RST_CYL;
            s.regs.drv_hd  <= `AHPD_RST_DRVHD;
            s.regs.dev_ctl <= `AHPD_RST_DEVCTL;
        end
        else if (clk_en)
            s <= n;
    end

    assign dd_out               = s.bus.data;
    assign dd_oe                = s.bus.oe;
    assign io16_n               = s.io16_n;
    assign dmarq                = s.dmarq;
    assign device_burst_ready_n = s.rdy_n;
    assign task_regs            = s.regs;
    assign cmd_code             = s.cmd_code;
    assign cmd_strobe           = s.cmd_strobe;
    assign pio_wdata            = s.pio_wdata;
    assign pio_wstrobe          = s.pio_wstrobe;
    assign pio_rstrobe          = s.pio_rstrobe;
    assign soft_reset           = s.regs.dev_ctl[`AHPD_DC_SRST];
    assign intr_off             = s.regs.dev_ctl[`AHPD_DC_INT_OFF];
    assign rx_overrun           = s.ov2;

    // cycle ages for the burst checks
    logic [7:0] rdy_age;
    logic [7:0] wr_age;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            rdy_age <= 8'h00;
            wr_age  <= 8'hff;
        end
        else if (clk_en)
        begin
            rdy_age <= !s.rdy_n ? 8'h00 : (rdy_age == 8'hff ? rdy_age : rdy_age + 8'h01);
            wr_age  <= rx_moved ? 8'h00 : (wr_age == 8'hff ? wr_age : wr_age + 8'h01);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b || !clk_en);

    property p_release;
        s.h2.rd_n |=> (s.bus.oe == 2'b00);
    endproperty
    a_release: assert property (p_release) else $error("bus driven with read negated");

    property p_both_sel;
        (!s.h2.cmd_sel_n && !s.h2.ctl_sel_n) |=> (s.bus.oe == 2'b00) && $stable(s.regs);
    endproperty
    a_both_sel: assert property (p_both_sel) else $error("invalid address had an effect");

    property p_ctl_low;
        (!s.h2.rd_n && ctl_blk(s.h2) && s.h2.da[2:1] != 2'b11) |=> (s.bus.oe == 2'b00);
    endproperty
    a_ctl_low: assert property (p_ctl_low) else $error("control location 0-5 drove bus");

    property p_ctl_byte;
        ctl_blk(s.h2) |=> !s.bus.oe[1];
    endproperty
    a_ctl_byte: assert property (p_ctl_byte) else $error("control block drove upper byte");

    property p_upper;
        s.bus.oe[1] |-> !s.io16_n && !$past(ecc_xfer);
    endproperty
    a_upper: assert property (p_upper) else $error("upper byte driven outside 16-bit data");

    property p_ecc;
        (ecc_xfer && !s.h2.rd_n && cmd_blk(s.h2)) |=> (s.bus.oe == 2'b01) && (s.bus.data[15:8] == 8'h00);
    endproperty
    a_ecc: assert property (p_ecc) else $error("correction byte used upper lanes");

    property p_wr_trail;
        (s.h2.wr_n && !s.hl.wr_n && cmd_blk(s.hl) && s.hl.da == `AHPD_A_SECCNT)
            |=> (s.regs.sec_cnt == $past(s.hl.dd[7:0]));
    endproperty
    a_wr_trail: assert property (p_wr_trail) else $error("sector count not written");

    property p_no_early_write;
        (!s.h2.wr_n && !s.hl.wr_n) |=> $stable(s.regs) && !s.cmd_strobe;
    endproperty
    a_no_early_write: assert property (p_no_early_write) else $error("write before trailing edge");

    property p_trp;
        $fell(s.dmarq) |-> (rdy_age >= trp_cyc(udma_mode)) && (wr_age >= 8'(`AHPD_TSS_CYC));
    endproperty
    a_trp: assert property (p_trp) else $error("request dropped too early");

    property p_pause;
        (s.burst == AHPD_BURST && rx_level >= PAUSE_LVL) |=> s.rdy_n;
    endproperty
    a_pause: assert property (p_pause) else $error("ready kept while buffer full");

    property p_stop_done;
        (s.burst == AHPD_BURST && burst_stop) |=> s.rdy_n ##[1:40] !s.dmarq;
    endproperty
    a_stop_done: assert property (p_stop_done) else $error("stop did not end burst");

    c_cmd: cover property (s.cmd_strobe);
    c_pause: cover property (s.burst == AHPD_BURST && $rose(s.rdy_n));
    c_end: cover property ($fell(s.dmarq));
    c_read16: cover property (s.bus.oe == 2'b11);
endmodule

// [tb/ahpd_host.sv]
`timescale 1ns/100ps
module ahpd_host
    import ahpd_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic [15:0] dd_out,
    input  wire logic [1:0]  dd_oe,
    input  wire logic        device_burst_ready_n,
    output logic             command_block_select_n,
    output logic             control_block_select_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic [2:0]       da,
    output logic [15:0]      dd,
    output logic             link_clk,
    output logic             dmack_n
);
    logic [15:0] sent[$];
    logic        idle;
    initial
    begin
        {command_block_select_n, control_block_select_n, rd_n, wr_n, dmack_n} = 5'h1f;
        {da, dd, link_clk, idle} = 21'h1;
    end
    // released bus never holds its last value
    always @(posedge sys_clk)
        if (idle)
            dd <= ~dd;
    task automatic cycle(input logic rd, input logic [1:0] s, input logic [2:0] a,
                         input logic [15:0] v, output logic [17:0] g);
        @(posedge sys_clk);
        idle <= rd;
        command_block_select_n <= ~s[1];
        control_block_select_n <= ~s[0];
        da <= a;
        @(posedge sys_clk);
        rd_n <= !rd;
        wr_n <= rd;
        // data waits one edge so the idle toggler has let go of the bus
        if (!rd)
            dd <= v;
        repeat (6) @(posedge sys_clk);
        g = {dd_oe, dd_out};
        {rd_n, wr_n} <= 2'h3;
        repeat (2) @(posedge sys_clk);
        {command_block_select_n, control_block_select_n} <= 2'h3;
        idle <= 1'h1;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic strobe();
        #40 link_clk = 1'h1;
        #40 link_clk = 1'h0;
    endtask
    task automatic ack(input logic v);
        @(posedge sys_clk);
        dmack_n <= v;
    endtask
    task automatic push(input logic [15:0] w[8]);
        idle = 1'h0;
        #13;
        for (int i = 0; i < 8; i++)
        begin
            if (device_burst_ready_n)
                break;
            dd = w[i];
            sent.push_back(w[i]);
            strobe();
        end
        idle = 1'h1;
    endtask
endmodule

// [tb/test_ahpd_port.sv]
`timescale 1ns/100ps
module test_ahpd_port
    import ahpd_pkg::*;
;
    logic        sys_clk = 1'h0;
    logic        rst_b = 1'h0;
    logic        rx_ready = 1'h1;
    logic        ecc_xfer = 1'h0;
    logic        write_gate = 1'h0;
    logic        burst_start = 1'h0;
    logic        burst_stop = 1'h0;
    logic [2:0]  udma_mode = 3'h0;
    logic [7:0]  core_status = 8'h00;
    logic [7:0]  core_error = 8'h00;
    logic [15:0] core_rdata = 16'h0000;
    logic        command_block_select_n, control_block_select_n, rd_n, wr_n, link_clk, dmack_n;
    logic        dmarq, device_burst_ready_n, soft_reset, intr_off, rx_valid, rx_overrun;
    logic        io16_n, cmd_strobe, pio_wstrobe, pio_rstrobe, io_seen;
    logic [7:0]  pulses[3] = '{8'h00, 8'h00, 8'h00};
    logic [2:0]  da;
    logic [1:0]  dd_oe;
    logic [15:0] h_dd, dd_in, dd_out, rx_data, pio_wdata;
    logic [7:0]  cmd_code;
    ahpd_regs_t  task_regs, er;
    logic [15:0] got[$];
    logic [15:0] w[8];
    int          seed = 53;
    int          failures = 0;
    int          num_checks = 0;

    assign dd_in = {dd_oe[1] ? dd_out[15:8] : h_dd[15:8], dd_oe[0] ? dd_out[7:0] : h_dd[7:0]};

    ahpd_port u_dut (
        .sys_clk, .rst_b, .clk_en(1'h1), .link_clk, .command_block_select_n, .control_block_select_n,
        .rd_n, .wr_n, .da, .dd_in, .dd_out, .dd_oe, .io16_n, .dmack_n, .dmarq, .device_burst_ready_n,
        .core_status, .core_error, .core_rdata, .ecc_xfer, .write_gate, .udma_mode, .burst_start,
        .burst_stop, .task_regs, .cmd_code, .cmd_strobe, .pio_wdata, .pio_wstrobe, .pio_rstrobe,
        .soft_reset, .intr_off, .rx_valid, .rx_ready, .rx_data, .rx_overrun
    );
    ahpd_host u_host (
        .sys_clk, .dd_out, .dd_oe, .device_burst_ready_n, .command_block_select_n,
        .control_block_select_n, .rd_n, .wr_n, .da, .dd(h_dd), .link_clk, .dmack_n
    );

    initial
        forever
            #4 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        if (rx_valid === 1'h1 && rx_ready === 1'h1)
            got.push_back(rx_data);
        if (!rd_n || !wr_n)
            io_seen <= io16_n;
        pulses[0] <= pulses[0] + {7'h00, cmd_strobe === 1'h1};
        pulses[1] <= pulses[1] + {7'h00, pio_wstrobe === 1'h1};
        pulses[2] <= pulses[2] + {7'h00, pio_rstrobe === 1'h1};
    end

    task automatic test_done();
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(string n, logic [89:0] e, logic [89:0] g);
        num_checks++;
        if (e !== g)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    function automatic int trp(int m);
        return ((m == 1 ? 125 : (m >= 2 && m <= 4) ? 100 : 160) + 7) / 8;
    endfunction

    function automatic logic [17:0] rd_exp(logic [1:0] s, logic [2:0] a);
        logic [63:0] t;
        t = {core_status, er.drv_hd, er.cyl_hi, er.cyl_lo, er.sec_num, er.sec_cnt, core_error, 8'h00};
        if (s == 2'h2 && a == 3'h0)
            return ecc_xfer ? {2'h1, 8'h00, core_rdata[7:0]} : {2'h3, core_rdata};
        if (s == 2'h2)
            return {2'h1, 8'h00, t[a*8 +: 8]};
        if (s == 2'h1 && a == 3'h6)
            return {2'h1, 8'h00, core_status};
        if (s == 2'h1 && a == 3'h7)
            return {2'h1, 9'h000, ~write_gate, ~er.drv_hd[3:0], ~er.drv_hd[4], er.drv_hd[4]};
        return 18'h0;
    endfunction

    task automatic op(logic rd, logic [1:0] s, logic [2:0] a, logic [15:0] v);
        logic [17:0] g;
        logic [7:0]  p[3];
        logic [23:0] pe;
        if (s == 2'h1)
            v = {v[15:4], 1'h1, v[2:1], 1'h0};
        p = pulses;
        u_host.cycle(rd, s, a, v, g);
        if (rd)
            chk("read", rd_exp(s, a), g);
        else
        begin
            if (s == 2'h2 && a != 3'h0 && a != 3'h7)
                er[(7 - a) * 8 +: 8] = v[7:0];
            if (s == 2'h1 && a == 3'h6)
                er.dev_ctl = v[7:0];
            chk("regs", {er, er.dev_ctl[2:1]}, {task_regs, soft_reset, intr_off});
            if (s == 2'h2 && a == 3'h7)
                chk("cmd", v[7:0], cmd_code);
            if (s == 2'h2 && a == 3'h0)
                chk("pio", v, pio_wdata);
        end
        chk("release", 2'h0, dd_oe);
        pe = {7'h00, !rd && a == 3'h7, 7'h00, !rd && a == 3'h0, 7'h00, rd && a == 3'h0} & {24{s == 2'h2}};
        chk("pulses", pe, {pulses[0] - p[0], pulses[1] - p[1], pulses[2] - p[2]});
        chk("io16", s != 2'h2 || a != 3'h0, io_seen);
    endtask

    initial
    begin
        #500000;
        failures++;
        test_done();
    end

    initial
    begin
        int          n;
        logic [31:0] r;
        fork
            repeat (4) u_host.strobe();
            repeat (8) @(posedge sys_clk);
        join
        @(posedge sys_clk);
        rst_b <= 1'h1;
        repeat (3) u_host.strobe();
        er = {8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h08};
        chk("reset", {er, 5'h02}, {task_regs, dd_oe, dmarq, device_burst_ready_n, rx_overrun});
        // every select pair and address, writes then reads
        for (int i = 0; i < 64; i++)
        begin
            r = $random(seed);
            op(i[5], i[4:3], i[2:0], r[15:0]);
        end
        for (int i = 0; i < 40; i++)
        begin
            r = $random(seed);
            @(posedge sys_clk);
            {core_status, core_error, ecc_xfer, write_gate} <= {r[31:16], r[1:0]};
            core_rdata <= r[17:2];
            op(r[6], r[8:7], r[11:9], r[27:12]);
        end
        for (int m = 0; m < 6; m++)
        begin
            for (int i = 0; i < 8; i++)
                w[i] = 16'($random(seed));
            @(posedge sys_clk);
            udma_mode <= m[2:0];
            burst_start <= 1'h1;
            @(posedge sys_clk);
            burst_start <= 1'h0;
            u_host.ack(1'h0);
            for (n = 0; n < 20 && device_burst_ready_n !== 1'h0; n++)
                @(posedge sys_clk);
            chk("dmarq", 1'h1, dmarq);
            chk("ready", 1'h0, device_burst_ready_n);
            rx_ready <= 1'h0;
            got.delete();
            u_host.sent.delete();
            u_host.push(w);
            repeat (8) @(posedge sys_clk);
            chk("full", 1'h1, device_burst_ready_n);
            chk("fill", 1'h1, u_host.sent.size() >= 5);
            rx_ready <= 1'h1;
            repeat (30) @(posedge sys_clk);
            chk("count", u_host.sent.size(), got.size());
            foreach (got[i])
                chk("word", u_host.sent[i], got[i]);
            burst_stop <= 1'h1;
            @(posedge sys_clk);
            burst_stop <= 1'h0;
            for (n = 0; n < 300 && dmarq === 1'h1; n++)
                @(posedge sys_clk);
            chk("pause", 1'h1, n >= trp(m) && n <= trp(m) + 12);
            chk("paused", 1'h1, device_burst_ready_n);
            u_host.ack(1'h1);
            repeat (8) @(posedge sys_clk);
        end
        chk("overrun", 1'h0, rx_overrun);
        test_done();
    end
endmodule
